// ---- core/hpw_pkg.sv ----
// Package for the host write port: widths, decode constants, timing counts.
package hpw_pkg;
	localparam int ADDR_W = 7; // A[7:1], word address
	localparam int DATA_W = 16;
	localparam int LOW_ADDR_W = 2; // A[2:1], still used in queue mode
	localparam int CLK_PERIOD_NS = 10;
	localparam int T_CYCLE_NS = 165;
	localparam int T_CSL_NS = 32;
	localparam int T_CSH_NS = 13;
	localparam int CYCLE_CLKS = (T_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CSL_CLKS = (T_CSL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CSH_CLKS = (T_CSH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int NUM_REGS = 128;
	localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
	localparam logic [ADDR_W-1:0] ADDR_RST = 7'h00;

	// One sampled host bus word
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic              queue_sel;
	} hpw_bus_t;

	// One committed update toward the register file or the queue
	typedef struct packed {
		logic              reg_we;
		logic [NUM_REGS-1:0] reg_sel;
		logic              queue_we;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} hpw_wr_t;

	typedef enum logic [1:0] {
		HPW_IDLE   = 2'b01,
		HPW_ACTIVE = 2'b10
	} hpw_state_t;
endpackage

// ---- core/hpw_write_port.sv ----
// Write side of the asynchronous 16-bit host port, sampled on clk.
// Operation
// - All host writes, to registers or the transmit queue, use this port.
// - A write cycle starts only when select and write strobe are both low.
// - A cycle ends when either or both strobes rise, in any order.
// - Each write cycle carries one 16-bit data word.
// - Queue select high during the access turns it into a queue write.
// - In queue mode the upper address is ignored and data goes to the queue.
// - Queue select has the same setup and hold as the address inputs.
// - Queue writes use the same framing and timing as ordinary writes.
`timescale 1ns/1ps
module hpw_write_port
	import hpw_pkg::*;
(
	input  wire logic                       clk,
	input  wire logic                       sys_rst,
	input  wire logic                       clk_en,
	input  wire logic                       host_select_n,
	input  wire logic                       write_strobe_n,
	input  wire hpw_pkg::hpw_bus_t          host_bus,
	output hpw_pkg::hpw_wr_t                wr_out,
	output logic                            cycle_active,
	output logic                            short_cycle_err
);
	import hpw_pkg::*;

	// Cycle framing state
	hpw_state_t          state_ff;
	hpw_state_t          nxt_state;
	logic                act_ff;
	logic                nxt_act;

	// Last bus sample taken while the strobes were both low
	hpw_bus_t            bus_ff;
	hpw_bus_t            nxt_bus;

	// Committed update toward the register file or the queue
	hpw_wr_t             wr_ff;
	hpw_wr_t             nxt_wr;

	// Host timing watch
	logic                err_ff;
	logic                nxt_err;
	logic [7:0]          low_cnt_ff;
	logic [7:0]          nxt_low_cnt;
	logic [7:0]          hi_cnt_ff;
	logic [7:0]          nxt_hi_cnt;
	logic [7:0]          cyc_cnt_ff;
	logic [7:0]          nxt_cyc_cnt;

	// Decoded events of the current sample
	logic                strobes_low;
	logic                cyc_start;
	logic                cyc_end;

	// Both strobes low frames the cycle; either rising closes it
	assign strobes_low = !host_select_n && !write_strobe_n;

	// Start and end are each one sample wide and never coincide
	assign cyc_start = (state_ff == HPW_IDLE) && strobes_low;
	assign cyc_end   = (state_ff == HPW_ACTIVE) && !strobes_low;

	// Framing: idle until both strobes are low, active until one rises
	always_comb
	begin
		nxt_state = state_ff;
		nxt_act   = 1'b0;
		case (state_ff)
			HPW_IDLE:
			begin
				if (strobes_low)
				begin
					nxt_state = HPW_ACTIVE;
					nxt_act   = 1'b1;
				end
			end
			HPW_ACTIVE:
			begin
				if (strobes_low)
				begin
					nxt_act = 1'b1;
				end
				else
				begin
					// Either order of release ends the cycle here
					nxt_state = HPW_IDLE;
				end
			end
			default:
			begin
				// A stray code falls back to idle rather than hang
				nxt_state = HPW_IDLE;
			end
		endcase
	end

	// Framing registers, frozen while the clock enable is low
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			state_ff <= HPW_IDLE;
			act_ff   <= 1'b0;
		end
		else if (clk_en)
		begin
			state_ff <= nxt_state;
			act_ff   <= nxt_act;
		end
	end

	// Capture: refresh on every asserted sample, since data only has to
	// settle shortly before the release and may still move before that
	always_comb
	begin
		nxt_bus = bus_ff;
		if (strobes_low)
		begin
			nxt_bus = host_bus;
		end
	end

	// Capture register; bus changes after the release are ignored
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			bus_ff <= '0;
		end
		else if (clk_en)
		begin
			bus_ff <= nxt_bus;
		end
	end

	// Commit: one pulse per completed cycle, built from the last sample
	always_comb
	begin
		nxt_wr      = '0;
		nxt_wr.addr = wr_ff.addr;
		nxt_wr.data = wr_ff.data;
		if (cyc_end)
		begin
			nxt_wr.addr = bus_ff.addr;
			nxt_wr.data = bus_ff.data;
			if (bus_ff.queue_sel)
			begin
				// Queue mode: address is reported but not decoded
				nxt_wr.queue_we = 1'b1;
			end
			else
			begin
				nxt_wr.reg_we = 1'b1;
				nxt_wr.reg_sel[bus_ff.addr] = 1'b1;
			end
		end
	end

	// Commit register; strobes clear themselves after one cycle
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			wr_ff <= '0;
		end
		else if (clk_en)
		begin
			wr_ff <= nxt_wr;
		end
	end

	// Timing watch. The whole cycle can only be judged at the next start,
	// since it includes the released phase; the write is taken anyway.
	always_comb
	begin
		nxt_err     = 1'b0;
		nxt_low_cnt = low_cnt_ff;
		nxt_hi_cnt  = hi_cnt_ff;
		nxt_cyc_cnt = cyc_cnt_ff;
		if (cyc_cnt_ff != 8'hff)
		begin
			nxt_cyc_cnt = cyc_cnt_ff + 8'h01;
		end
		if (strobes_low && (low_cnt_ff != 8'hff))
		begin
			nxt_low_cnt = low_cnt_ff + 8'h01;
		end
		if (!strobes_low && (hi_cnt_ff != 8'hff))
		begin
			nxt_hi_cnt = hi_cnt_ff + 8'h01;
		end
		if (cyc_start)
		begin
			nxt_low_cnt = 8'h01;
			nxt_hi_cnt  = 8'h00;
			nxt_cyc_cnt = 8'h01;
			// Start to start too short, or released phase too short
			nxt_err = (cyc_cnt_ff < 8'(CYCLE_CLKS))
				|| (hi_cnt_ff < 8'(CSH_CLKS));
		end
		if (cyc_end)
		begin
			// Asserted phase too short
			nxt_err = (low_cnt_ff < 8'(CSL_CLKS));
		end
	end

	// Timing registers; the cycle and released-phase counters start saturated
	// so the first start after reset is never flagged
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			err_ff     <= 1'b0;
			low_cnt_ff <= 8'h00;
			hi_cnt_ff  <= 8'hff;
			cyc_cnt_ff <= 8'hff;
		end
		else if (clk_en)
		begin
			err_ff     <= nxt_err;
			low_cnt_ff <= nxt_low_cnt;
			hi_cnt_ff  <= nxt_hi_cnt;
			cyc_cnt_ff <= nxt_cyc_cnt;
		end
	end

	// Outputs come straight from the registers above
	assign wr_out          = wr_ff;
	assign cycle_active    = act_ff;
	assign short_cycle_err = err_ff;
endmodule

// ---- verification/hpw_write_port_sva.sv ----
// Checker for the host write port.
`timescale 1ns/1ps
module hpw_write_port_sva
	import hpw_pkg::*;
(
	input wire logic     clk,
	input wire logic     sys_rst,
	input wire logic     clk_en,
	input wire logic     host_select_n,
	input wire logic     write_strobe_n,
	input wire hpw_bus_t host_bus,
	input wire hpw_wr_t  wr_out,
	input wire logic     cycle_active,
	input wire logic     short_cycle_err
);
	// Both strobes low, and the first edge after a live cycle ends
	wire act = clk_en && !host_select_n && !write_strobe_n;
	wire fin = clk_en && cycle_active && !act;
	wire we = wr_out.reg_we || wr_out.queue_we;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	start_a: assert property (act |=> cycle_active)
		else $error("start");
	end_a: assert property (clk_en && !act |=> !cycle_active)
		else $error("end");
	commit_a: assert property (fin |=> wr_out.reg_we ^ wr_out.queue_we)
		else $error("commit");
	once_a: assert property (we |-> !cycle_active && $past(cycle_active))
		else $error("once");
	queue_a: assert property (fin && $past(host_bus.queue_sel) |=>
		wr_out.queue_we) else $error("queue");
	reg_a: assert property (fin && !$past(host_bus.queue_sel) |=>
		wr_out.reg_sel == 128'h1 << $past(host_bus.addr, 2)) else $error("reg");
	word_a: assert property (fin |=>
		{wr_out.addr, wr_out.data} == $past({host_bus.addr, host_bus.data}, 2))
		else $error("word");
	hold_a: assert property (!we |-> $stable(wr_out.data))
		else $error("hold");
endmodule
bind hpw_write_port hpw_write_port_sva i_sva (.*);

// ---- verification/hpw_host.sv ----
// Host model running framed write cycles.
`timescale 1ns/1ps
module hpw_host (
	input  wire logic          clk,
	output logic               sel_n,
	output logic               str_n,
	output hpw_pkg::hpw_bus_t  bus
);
	// Asserted 5 clocks, cycle 17 plus gap, released bus inverted
	task automatic wr(hpw_pkg::hpw_bus_t b, bit ord, int gap);
		@(negedge clk) {sel_n, str_n, bus} <= {ord, !ord, b};
		@(negedge clk) {sel_n, str_n} <= 2'b00;
		repeat (5) @(negedge clk);
		{sel_n, str_n} <= {!ord, ord};
		@(negedge clk) {sel_n, str_n, bus} <= {2'b11, ~b};
		repeat (9 + gap) @(negedge clk);
	endtask
	initial {sel_n, str_n, bus} = '1;
endmodule

// ---- verification/hpw_write_port_tb.sv ----
// Bench for the host write port with a queue reference.
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_total++; \
	$display("CHECK FAILED %0t %h %h", $time, a, b); end end
module hpw_write_port_tb;
	import hpw_pkg::*;
	logic     clk = 0, sys_rst = 1, sel_n, str_n, act, err;
	hpw_bus_t bus, b, e;
	hpw_wr_t  w;
	hpw_bus_t exp_q[$];
	int       err_total = 0, checks_done = 0, err_seen = 0, exp_err = 0;
	hpw_write_port i_hpw_write_port (.clk(clk), .sys_rst(sys_rst),
		.clk_en(1'b1), .host_select_n(sel_n), .write_strobe_n(str_n),
		.host_bus(bus), .wr_out(w), .cycle_active(act), .short_cycle_err(err));
	hpw_host i_hpw_host (.clk(clk), .sel_n(sel_n), .str_n(str_n), .bus(bus));
	initial forever #5 clk = ~clk;
	// Every commit is held against the oldest word sent
	always @(negedge clk) if (err === 1'b1) err_seen++;
	always @(negedge clk) if (w.reg_we === 1'b1 || w.queue_we === 1'b1)
	begin
		e = exp_q.pop_front();
		`CHK({w.queue_we, w.addr, w.data}, {e.queue_sel, e.addr, e.data})
		`CHK(w.reg_sel, e.queue_sel ? 128'h0 : 128'h1 << e.addr)
		`CHK(err_seen, exp_err)
	end
	task automatic final_report;
		if (err_total == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Watchdog well beyond 40 cycles of at most 19 clocks
	initial
	begin
		#30000;
		err_total++;
		final_report;
	end
	initial
	begin
		void'($urandom(32'h044b630d));
		repeat (20) @(negedge clk);
		sys_rst = 0;
		repeat (40)
		begin
			b = $bits(b)'($urandom);
			exp_q.push_back(b);
			i_hpw_host.wr(b, $urandom % 2, $urandom % 3);
		end
		// A cycle two clocks short must raise one flag at the next start
		b = $bits(b)'($urandom);
		exp_q.push_back(b);
		i_hpw_host.wr(b, 1'b0, -2);
		exp_err = 1;
		b = $bits(b)'($urandom);
		exp_q.push_back(b);
		i_hpw_host.wr(b, 1'b1, 0);
		// Reset in mid-run, then one more write
		sys_rst = 1;
		repeat (2) @(negedge clk);
		sys_rst = 0;
		b = $bits(b)'($urandom);
		exp_q.push_back(b);
		i_hpw_host.wr(b, 1'b0, 0);
		repeat (4) @(negedge clk);
		`CHK(exp_q.size(), 0)
		final_report;
	end
endmodule
